// ==== board_control_port_map.sv ====
// board_control_port_map: two port/timer units behind one byte-wide register port
// assumes the master holds the address, data and strobes stable for the strobe cycle
`timescale 1ns/1ps

//////////////////////////////////////////////////////////////////////////////////////////
// port_timer_unit: three 8-bit ports in bit i/o mode plus a 24-bit down counter
module port_timer_unit
  import board_ctl_pkg::*;
(
  // clock and reset
  input  wire logic       sys_clk,
  input  wire logic       rstn,
  // register access
  input  wire logic       sel,
  input  wire logic       wr_stb,
  input  wire logic [5:0] reg_ofs,
  input  wire logic [7:0] wr_data,
  output logic      [7:0] rd_data,
  // pins
  input  wire logic [7:0] port_a_in,
  input  wire logic [7:0] port_b_in,
  input  wire logic [7:0] port_c_in,
  input  wire logic [3:0] hs_in,
  output logic      [7:0] port_a_out,
  output logic      [7:0] port_a_oe,
  output logic      [7:0] port_b_out,
  output logic      [7:0] port_b_oe,
  output logic      [7:0] port_c_out,
  output logic      [7:0] port_c_oe,
  output logic            tmr_zero
);
  logic [7:0]  gen_q;
  logic [7:0]  a_dir_q;
  logic [7:0]  b_dir_q;
  logic [7:0]  c_dir_q;
  logic [7:0]  a_ctl_q;
  logic [7:0]  b_ctl_q;
  logic [7:0]  a_dat_q;
  logic [7:0]  b_dat_q;
  logic [7:0]  c_dat_q;
  logic [7:0]  tcr_q;
  logic [7:0]  tvec_q;
  logic [7:0]  tstat_q;
  logic [23:0] pre_q;
  logic [23:0] cnt_q;
  logic [4:0]  div_q;
  logic        we;
  logic        tick;
  logic        run;
  logic        hit;
  logic [7:0]  pin_a;
  logic [7:0]  pin_b;
  logic [7:0]  pin_c;

  assign we   = sel & wr_stb;
  assign run  = tcr_q[TMR_EN_BIT];
  assign tick = run & (div_q == 5'(TMR_PRESCALE_DIV - 1));
  assign hit  = tick & (cnt_q == CNT_RESET);
  // each pin its own direction and level
  assign pin_a = (a_dir_q & a_dat_q) | (~a_dir_q & port_a_in);
  assign pin_b = (b_dir_q & b_dat_q) | (~b_dir_q & port_b_in);
  assign pin_c = (c_dir_q & c_dat_q) | (~c_dir_q & port_c_in);

  // reset leaves every pin an input
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      gen_q   <= REG_RESET;
      a_dir_q <= REG_RESET;
      b_dir_q <= REG_RESET;
      c_dir_q <= REG_RESET;
      a_ctl_q <= REG_RESET;
      b_ctl_q <= REG_RESET;
      a_dat_q <= REG_RESET;
      b_dat_q <= REG_RESET;
      c_dat_q <= REG_RESET;
      tcr_q   <= REG_RESET;
      tvec_q  <= REG_RESET;
    end else if (we) begin
      if (reg_ofs == GEN_CTRL_OFS) gen_q <= wr_data;
      else if (reg_ofs == A_DIR_OFS) a_dir_q <= wr_data;
      else if (reg_ofs == B_DIR_OFS) b_dir_q <= wr_data;
      else if (reg_ofs == C_DIR_OFS) c_dir_q <= wr_data;
      else if (reg_ofs == A_CTRL_OFS) a_ctl_q <= wr_data;
      else if (reg_ofs == B_CTRL_OFS) b_ctl_q <= wr_data;
      else if (reg_ofs == A_DATA_OFS) a_dat_q <= wr_data;
      else if (reg_ofs == B_DATA_OFS) b_dat_q <= wr_data;
      else if (reg_ofs == C_DATA_OFS) c_dat_q <= wr_data;
      else if (reg_ofs == TMR_CTRL_OFS) tcr_q <= wr_data;
      else if (reg_ofs == TMR_VEC_OFS) tvec_q <= wr_data;
    end
  end

  // timer: preload, down count, zero status; set wins over a status clear
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      pre_q   <= CNT_RESET;
      cnt_q   <= CNT_RESET;
      div_q   <= 5'h00;
      tstat_q <= REG_RESET;
    end else begin
      div_q <= run ? div_q + 5'h01 : 5'h00;
      if (we && reg_ofs == TMR_PRE_HI_OFS) pre_q[23:16] <= wr_data;
      if (we && reg_ofs == TMR_PRE_MI_OFS) pre_q[15:8]  <= wr_data;
      if (we && reg_ofs == TMR_PRE_LO_OFS) pre_q[7:0]   <= wr_data;
      if (!run || hit) cnt_q <= pre_q;
      else if (tick) cnt_q <= cnt_q - 24'h000001;
      if (hit) tstat_q[0] <= 1'b1;
      else if (we && reg_ofs == TMR_STAT_OFS && wr_data[0]) tstat_q[0] <= 1'b0;
    end
  end

  // every register readable
  // status reads put the handshake levels over the zero flag position
  always_comb begin
    rd_data = REG_RESET;
    if (reg_ofs == GEN_CTRL_OFS) rd_data = gen_q;
    else if (reg_ofs == A_DIR_OFS) rd_data = a_dir_q;
    else if (reg_ofs == B_DIR_OFS) rd_data = b_dir_q;
    else if (reg_ofs == C_DIR_OFS) rd_data = c_dir_q;
    else if (reg_ofs == A_CTRL_OFS) rd_data = a_ctl_q;
    else if (reg_ofs == B_CTRL_OFS) rd_data = b_ctl_q;
    else if (reg_ofs == A_DATA_OFS) rd_data = pin_a;
    else if (reg_ofs == B_DATA_OFS) rd_data = pin_b;
    else if (reg_ofs == C_DATA_OFS) rd_data = pin_c;
    else if (reg_ofs == TMR_CTRL_OFS) rd_data = tcr_q;
    else if (reg_ofs == TMR_VEC_OFS) rd_data = tvec_q;
    else if (reg_ofs == TMR_PRE_HI_OFS) rd_data = pre_q[23:16];
    else if (reg_ofs == TMR_PRE_MI_OFS) rd_data = pre_q[15:8];
    else if (reg_ofs == TMR_PRE_LO_OFS) rd_data = pre_q[7:0];
    else if (reg_ofs == TMR_CNT_HI_OFS) rd_data = cnt_q[23:16];
    else if (reg_ofs == TMR_CNT_MI_OFS) rd_data = cnt_q[15:8];
    else if (reg_ofs == TMR_CNT_LO_OFS) rd_data = cnt_q[7:0];
    else if (reg_ofs == TMR_STAT_OFS) rd_data = {tstat_q[7:4], hs_in};
  end

  assign port_a_out = a_dat_q;
  assign port_a_oe  = a_dir_q;
  assign port_b_out = b_dat_q;
  assign port_b_oe  = b_dir_q;
  assign port_c_out = c_dat_q;
  assign port_c_oe  = c_dir_q;
  assign tmr_zero   = tstat_q[0];

endmodule : port_timer_unit

//////////////////////////////////////////////////////////////////////////////////////////
module board_control_port_map
  import board_ctl_pkg::*;
#(
  parameter logic [23:0] BOARD_BASE = DEFAULT_BOARD_BASE
) (
  // clock and reset
  input  wire logic        sys_clk,
  input  wire logic        rstn,
  // byte register port
  input  wire logic [23:0] addr,
  input  wire logic        rd_stb,
  input  wire logic        wr_stb,
  input  wire logic        low_lane_en,
  input  wire logic [7:0]  wr_data,
  output logic      [7:0]  rd_data,
  output logic             ack,
  // first unit pins
  input  wire logic [7:0]  u1_port_b_in,
  output logic      [7:0]  u1_port_b_out,
  output logic      [7:0]  u1_port_b_oe,
  // second unit pins
  input  wire logic [7:0]  u2_port_b_in,
  input  wire logic [7:0]  u2_port_c_in,
  input  wire logic [3:0]  user_irq_in,
  output logic      [7:0]  u2_port_a_out,
  output logic      [7:0]  u2_port_a_oe,
  output logic      [7:0]  u2_port_c_out,
  output logic      [7:0]  u2_port_c_oe,
  // board functions
  input  wire logic        listener_irq,
  output logic      [2:0]  data_timeout_sel,
  output logic             iack_timeout_sel,
  output logic             bus_timer_en,
  output logic             power_fail_clear,
  output logic             reset_request,
  output logic      [7:0]  prog_irq_ch9_16,
  output logic      [2:0]  bclr_mode,
  output logic             bclr_out,
  output logic             gpib_dir,
  output logic             irq_ch1,
  output logic             irq_ch2,
  output logic             irq_ch8
);
  logic [23:0] rel;
  logic        in_board;
  logic        odd;
  logic        sel1;
  logic        sel2;
  logic [7:0]  rd1;
  logic [7:0]  rd2;
  logic [7:0]  u1_b_pin;
  logic [7:0]  u2_c_pin;
  logic        tz1;
  logic        tz2;

  assign rel      = addr - BOARD_BASE;
  assign in_board = (rel[23:12] == 12'h000);
  assign odd      = addr[0];
  assign sel1 = in_board & odd & low_lane_en &
                ((rel[11:0] & UNIT_WINDOW_MASK) == FIRST_UNIT_OFFSET);
  assign sel2 = in_board & odd & low_lane_en &
                ((rel[11:0] & UNIT_WINDOW_MASK) == SECOND_UNIT_OFFSET);
  assign ack  = (rd_stb | wr_stb) & (sel1 | sel2);
  assign rd_data = (rd_stb & sel1) ? rd1 : (rd_stb & sel2) ? rd2 : REG_RESET;

  // undriven pins read high through pull-ups
  assign u1_b_pin = (u1_port_b_oe & u1_port_b_out) | (~u1_port_b_oe & 8'hFF);
  assign u2_c_pin = (u2_port_c_oe & u2_port_c_out) | (~u2_port_c_oe & 8'hFF);

  // first unit, timer gives periodic irq
  // ports a and c of this unit are not wired on the board; they read the pull-ups
  port_timer_unit u_first (
    .sys_clk    (sys_clk),
    .rstn       (rstn),
    .sel        (sel1),
    .wr_stb     (wr_stb),
    .reg_ofs    (rel[5:0]),
    .wr_data    (wr_data),
    .rd_data    (rd1),
    .port_a_in  (8'hFF),
    .port_b_in  (u1_port_b_in),
    .port_c_in  (8'hFF),
    .hs_in      (4'hF),
    .port_a_out (),
    .port_a_oe  (),
    .port_b_out (u1_port_b_out),
    .port_b_oe  (u1_port_b_oe),
    .port_c_out (),
    .port_c_oe  (),
    .tmr_zero   (tz1)
  );

  // handshakes carry user irqs
  // port b only reads the address switches, so its drive stays inside
  port_timer_unit u_second (
    .sys_clk    (sys_clk),
    .rstn       (rstn),
    .sel        (sel2),
    .wr_stb     (wr_stb),
    .reg_ofs    (rel[5:0]),
    .wr_data    (wr_data),
    .rd_data    (rd2),
    .port_a_in  (8'hFF),
    .port_b_in  (u2_port_b_in),
    .port_c_in  (u2_port_c_in),
    .hs_in      (user_irq_in),
    .port_a_out (u2_port_a_out),
    .port_a_oe  (u2_port_a_oe),
    .port_b_out (),
    .port_b_oe  (),
    .port_c_out (u2_port_c_out),
    .port_c_oe  (u2_port_c_oe),
    .tmr_zero   (tz2)
  );

  assign data_timeout_sel = u1_b_pin[2:0];
  assign iack_timeout_sel = u1_b_pin[3];
  assign bus_timer_en     = u1_b_pin[4];
  // power fail clear and reset request
  assign power_fail_clear = u1_b_pin[6];
  assign reset_request    = ~u1_b_pin[7];
  assign prog_irq_ch9_16  = (u2_port_a_oe & u2_port_a_out) | (~u2_port_a_oe & 8'hFF);
  // bus-clear mode pins and output from timer
  assign bclr_mode        = {u2_c_pin[4], u2_c_pin[1], u2_c_pin[0]};
  assign bclr_out         = u2_c_pin[3] & ~tz2;
  assign gpib_dir         = u2_c_pin[6];
  // combined user irq to channel 1
  assign irq_ch1          = ~(user_irq_in != 4'hF) & u2_c_pin[5];
  assign irq_ch2          = tz1;
  assign irq_ch8          = listener_irq;

endmodule : board_control_port_map

// ==== board_ctl_pkg.sv ====
// board_ctl_pkg: offsets, register indices and reset values of the board control port
// assumes byte accesses on data lanes 7..0 with a byte address relative to any board base
package board_ctl_pkg;

  localparam logic [11:0] FIRST_UNIT_OFFSET  = 12'h040;
  localparam logic [11:0] SECOND_UNIT_OFFSET = 12'h080;
  localparam logic [11:0] UNIT_WINDOW_MASK   = 12'hFC0;
  localparam logic [23:0] DEFAULT_BOARD_BASE = 24'hB02000;

  // register byte offsets inside a unit window; all odd
  localparam logic [5:0] GEN_CTRL_OFS   = 6'h01;
  localparam logic [5:0] A_DIR_OFS      = 6'h05;
  localparam logic [5:0] B_DIR_OFS      = 6'h07;
  localparam logic [5:0] C_DIR_OFS      = 6'h09;
  localparam logic [5:0] A_CTRL_OFS     = 6'h0D;
  localparam logic [5:0] B_CTRL_OFS     = 6'h0F;
  localparam logic [5:0] A_DATA_OFS     = 6'h11;
  localparam logic [5:0] B_DATA_OFS     = 6'h13;
  localparam logic [5:0] C_DATA_OFS     = 6'h19;
  localparam logic [5:0] TMR_CTRL_OFS   = 6'h21;
  localparam logic [5:0] TMR_VEC_OFS    = 6'h23;
  localparam logic [5:0] TMR_PRE_HI_OFS = 6'h27;
  localparam logic [5:0] TMR_PRE_MI_OFS = 6'h29;
  localparam logic [5:0] TMR_PRE_LO_OFS = 6'h2B;
  localparam logic [5:0] TMR_CNT_HI_OFS = 6'h2F;
  localparam logic [5:0] TMR_CNT_MI_OFS = 6'h31;
  localparam logic [5:0] TMR_CNT_LO_OFS = 6'h33;
  localparam logic [5:0] TMR_STAT_OFS   = 6'h35;

  localparam logic [7:0]  REG_RESET   = 8'h00;
  localparam logic [23:0] CNT_RESET   = 24'h000000;
  localparam int          TMR_EN_BIT  = 0;
  localparam int          TMR_PRESCALE_DIV = 32;

endpackage : board_ctl_pkg

// ==== board_ctl_chk_properties.sv ====
// board_ctl_chk: port-level properties of the board control port
// assumes it is bound onto board_control_port_map, one sys_clk domain
`timescale 1ns/1ps
module board_ctl_chk
  import board_ctl_pkg::*;
#(
  parameter logic [23:0] BOARD_BASE = DEFAULT_BOARD_BASE
) (
  input wire logic        sys_clk,
  input wire logic        rstn,
  input wire logic [23:0] addr,
  input wire logic        rd_stb,
  input wire logic        wr_stb,
  input wire logic        low_lane_en,
  input wire logic [7:0]  rd_data,
  input wire logic        ack,
  input wire logic [7:0]  u1_port_b_out,
  input wire logic [7:0]  u1_port_b_oe,
  input wire logic [7:0]  u2_port_a_out,
  input wire logic [7:0]  u2_port_a_oe,
  input wire logic [7:0]  u2_port_c_out,
  input wire logic [7:0]  u2_port_c_oe,
  input wire logic [3:0]  user_irq_in,
  input wire logic        listener_irq,
  input wire logic [2:0]  data_timeout_sel,
  input wire logic        iack_timeout_sel,
  input wire logic        bus_timer_en,
  input wire logic        reset_request,
  input wire logic [7:0]  prog_irq_ch9_16,
  input wire logic [2:0]  bclr_mode,
  input wire logic        irq_ch1,
  input wire logic        irq_ch8
);
  wire logic [23:0] ofs = addr - BOARD_BASE;
  wire logic        hit = low_lane_en && addr[0] && (ofs[23:6] == 18'h1 || ofs[23:6] == 18'h2);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rstn);
  chk_ack_decode: assert property (ack |-> hit)
    else $error("ack outside an odd low-lane window");
  chk_ack_cause: assert property ((rd_stb || wr_stb) && hit |-> ack)
    else $error("valid access not acknowledged");
  chk_refused_read: assert property (rd_stb && !ack |-> rd_data == 8'h00)
    else $error("refused read returned data");
  chk_oe_after_write: assert property ($changed(u2_port_a_oe) |-> $past(wr_stb && ack))
    else $error("pin direction changed without a write");
  chk_bus_timer_sel: assert property ({bus_timer_en, iack_timeout_sel, data_timeout_sel}
    == (u1_port_b_out[4:0] | ~u1_port_b_oe[4:0]))
    else $error("bus timer selects differ from pins");
  chk_reset_req: assert property (reset_request == (u1_port_b_oe[7] && !u1_port_b_out[7]))
    else $error("reset request differs from pin");
  chk_prog_irq_pins: assert property (prog_irq_ch9_16 == (u2_port_a_out | ~u2_port_a_oe))
    else $error("programmable requests differ from pins");
  chk_bclr_mode_sel: assert property (bclr_mode == ({u2_port_c_out[4], u2_port_c_out[1:0]}
    | ~{u2_port_c_oe[4], u2_port_c_oe[1:0]}))
    else $error("bus clear mode differs from pins");
  chk_user_irq_merge: assert property (!(&user_irq_in) |-> !irq_ch1)
    else $error("user request not merged");
  chk_listener_route: assert property (irq_ch8 == listener_irq)
    else $error("listener request not routed");
endmodule : board_ctl_chk

bind board_control_port_map board_ctl_chk #(.BOARD_BASE(BOARD_BASE)) chk_i (.*);

// ==== board_ctl_master.sv ====
// board_ctl_master: bus master model issuing byte register accesses
// assumes the shared sys_clk and a released reset before the first call
`timescale 1ns/1ps
module board_ctl_master (
  input  wire logic        sys_clk,
  input  wire logic        ack,
  input  wire logic [7:0]  rd_data,
  output logic      [23:0] addr,
  output logic             rd_stb,
  output logic             wr_stb,
  output logic             low_lane_en,
  output logic      [7:0]  wr_data
);
  initial begin
    addr = 24'h000000;
    {rd_stb, wr_stb, low_lane_en} = 3'h0;
    wr_data = 8'h00;
  end
  // byte cycle on the low lane, held until ack or give-up
  task automatic xfer(input logic wr, input logic [23:0] a, input logic [7:0] d,
                      input logic lane, output logic [7:0] q, output logic got);
    got = 1'b0;
    q = 8'h00;
    @(posedge sys_clk);
    addr <= a;
    {rd_stb, wr_stb, low_lane_en} <= {!wr, wr, lane};
    wr_data <= d;
    for (int i = 0; i < 4 && !got; i++) begin
      @(posedge sys_clk);
      got = ack;
      q = rd_data;
    end
    // released lines must not keep showing the old value
    addr <= ~a;
    wr_data <= ~d;
    {rd_stb, wr_stb, low_lane_en} <= 3'h0;
  endtask : xfer
endmodule : board_ctl_master

// ==== board_control_port_map_tb_top.sv ====
// board_control_port_map_tb_top: directed register sequences on the board control port
// assumes the master model drives the bus; this bench models pins and pull-ups
`timescale 1ns/1ps
module board_control_port_map_tb_top
  import board_ctl_pkg::*;
;
  logic        sys_clk, rstn, rd_stb, wr_stb, low_lane_en, ack, listener_irq, got;
  logic        iack_timeout_sel, bus_timer_en, power_fail_clear, reset_request;
  logic        bclr_out, gpib_dir, irq_ch1, irq_ch2, irq_ch8;
  logic [23:0] addr;
  logic [7:0]  wr_data, rd_data, u1_port_b_in, u1_port_b_out, u1_port_b_oe, u2_port_b_in;
  logic [7:0]  u2_port_c_in, u2_port_a_out, u2_port_a_oe, u2_port_c_out, u2_port_c_oe;
  logic [7:0]  prog_irq_ch9_16, c_ext, q;
  logic [3:0]  user_irq_in;
  logic [2:0]  data_timeout_sel, bclr_mode;
  int          failures, cmp_count;
`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin failures++; \
  $display("BAD t=%0t got=%h exp=%h", $time, a, b); end end

  board_control_port_map DUT (.*);
  board_ctl_master master (.*);
  // pull-ups win wherever no side drives the pin
  assign u1_port_b_in = (u1_port_b_out & u1_port_b_oe) | ~u1_port_b_oe;
  assign u2_port_c_in = (u2_port_c_out & u2_port_c_oe) | (c_ext & ~u2_port_c_oe);

  function automatic logic [23:0] ra(input int u, input logic [5:0] o);
    return DEFAULT_BOARD_BASE + 24'(u ? SECOND_UNIT_OFFSET : FIRST_UNIT_OFFSET) + 24'(o);
  endfunction : ra
  task automatic wr(input logic [23:0] a, input logic [7:0] d);
    master.xfer(1'b1, a, d, 1'b1, q, got);
    // pins change only after the write edge has updated the registers
    @(negedge sys_clk);
    `CHK(got, 1'b1)
  endtask : wr
  task automatic rd(input logic [23:0] a, input logic [7:0] e);
    master.xfer(1'b0, a, 8'h00, 1'b1, q, got);
    `CHK(q, e)
  endtask : rd
  task automatic close_out;
    if (failures == 0 && cmp_count > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : close_out

  //////////////////////////////////////////////////////////////////////////////////////////
  initial begin
    sys_clk = 1'b0;
    forever #10 sys_clk = ~sys_clk;
  end
  initial begin
    rstn = 1'b0;
    {listener_irq, user_irq_in, u2_port_b_in, c_ext} = {1'b0, 4'hF, 8'h15, 8'hFF};
    failures = 0;
    cmp_count = 0;
    repeat (10) @(posedge sys_clk);
    rstn <= 1'b1;
    @(negedge sys_clk);
    `CHK({u1_port_b_oe, u2_port_a_oe, u2_port_c_oe}, 24'h000000)
    `CHK({prog_irq_ch9_16, bclr_mode, gpib_dir, reset_request}, 13'h1FFE)
    rd(24'hB02041, REG_RESET);
    rd(24'hB02081, REG_RESET);
    for (int u = 0; u < 2; u++) begin
      wr(ra(u, TMR_VEC_OFS), 8'hA5 ^ 8'(u));
      rd(ra(u, TMR_VEC_OFS), 8'hA5 ^ 8'(u));
    end
    wr(ra(1, A_DATA_OFS), 8'h00);
    `CHK(prog_irq_ch9_16, 8'hFF)
    wr(ra(1, A_DIR_OFS), 8'hFF);
    wr(ra(1, A_DATA_OFS), 8'h5A);
    `CHK(prog_irq_ch9_16, 8'h5A)
    rd(ra(1, A_DATA_OFS), 8'h5A);
    wr(ra(0, B_DATA_OFS), 8'hEE);
    wr(ra(0, B_DIR_OFS), 8'hDF);
    `CHK({data_timeout_sel, iack_timeout_sel, bus_timer_en, power_fail_clear}, 6'h35)
    `CHK(reset_request, 1'b0)
    wr(ra(0, B_DATA_OFS), 8'h6E);
    `CHK(reset_request, 1'b1)
    wr(ra(1, C_DATA_OFS), 8'hFD);
    wr(ra(1, C_DIR_OFS), 8'h5B);
    `CHK({bclr_mode, gpib_dir, bclr_out}, 5'h17)
    rd(ra(1, B_DATA_OFS), 8'h15);
    listener_irq <= 1'b1;
    user_irq_in <= 4'hB;
    @(negedge sys_clk);
    `CHK({irq_ch8, irq_ch1}, 2'b10)
    @(posedge sys_clk);
    user_irq_in <= 4'hF;
    @(negedge sys_clk);
    `CHK(irq_ch1, 1'b1)
    for (int k = 0; k < 3; k++) begin
      master.xfer(1'b1, ra(1, A_DATA_OFS) + (k == 1 ? 24'hFFFFFF : k == 2 ? 24'h80 : 24'h0),
                  8'h00, k != 0, q, got);
      `CHK(got, 1'b0)
    end
    `CHK(prog_irq_ch9_16, 8'h5A)
    master.xfer(1'b0, ra(0, GEN_CTRL_OFS) - 24'h1, 8'h00, 1'b1, q, got);
    `CHK({got, q}, 9'h000)
    for (int u = 0; u < 2; u++) begin
      wr(ra(u, TMR_PRE_LO_OFS), 8'h02);
      wr(ra(u, TMR_CTRL_OFS), 8'h01);
      for (int i = 0; i < 400 && (u ? bclr_out : !irq_ch2); i++) @(posedge sys_clk);
      `CHK(u ? bclr_out : irq_ch2, u ? 1'b0 : 1'b1)
      wr(ra(u, TMR_CTRL_OFS), 8'h00);
      wr(ra(u, TMR_STAT_OFS), 8'h01);
      @(negedge sys_clk);
      `CHK({irq_ch2, bclr_out}, 2'b01)
    end
    // a mid-run reset must drop every driven pin back to a pulled-up input
    @(posedge sys_clk);
    rstn <= 1'b0;
    repeat (2) @(posedge sys_clk);
    rstn <= 1'b1;
    @(negedge sys_clk);
    `CHK({u1_port_b_oe, u2_port_a_oe, u2_port_c_oe, prog_irq_ch9_16, reset_request}, 33'h0000001FE)
    close_out();
  end
endmodule : board_control_port_map_tb_top
